/* pfp_map.vh */
// constants for the fifo packing data path
`ifndef PFP_MAP_VH
`define PFP_MAP_VH
`define PFP_ADDR_CTRL 12'h000
`define PFP_ADDR_STAT 12'h004
`define PFP_ADDR_WLO 12'h008
`define PFP_ADDR_WHI 12'h00C
`define PFP_ADDR_WBE 12'h010
`define PFP_ADDR_ADDR 12'h014
`define PFP_ADDR_RDAT 12'h018
`define PFP_ADDR_LAST 12'h01C
`define PFP_CTRL_QUAD 0
`define PFP_CTRL_MCLK 1
`define PFP_CTRL_TCLK 2
`define PFP_CTRL_ACMP 3
`define PFP_CTRL_XLAT 4
`define PFP_CTRL_W64 5
`define PFP_CTRL_RST 32'h0000_0001
`define PFP_LAT_NORMAL 6'd16
`define PFP_LAT_EXTENDED 6'd32
`define PFP_BE_NONE 4'hF
`define PFP_BE_ALL 4'h0
`define PFP_ADDR_MSB 32'hFFFF_FF00
`define PFP_ADDR_LEAD 2
`endif

/* pfp_core.v */
// fifo packing/unpacking data path with apb control
//
// Function
// - dual or quad port organisation selectable
// - master fifo clock select array one/two
// - target fifo clock select, independent
// - comparator skips repeated upper address bytes
// - initial latency limit 16 or 32
// - quad mode user words are 32 bits
// - 64-bit entries pass through unrepacked
// - low half first, active-low enables 35:32
// - 32-bit words packed by start address
// - empty half gives dummy, enables off
// - aligned even bursts pack two per entry
`timescale 1ns/1ns
`default_nettype none
`include "pfp_map.vh"
module pfp_core #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire array_clock_one_i,
    input wire array_clock_two_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    output wire master_fifo_clk_o,
    output wire target_fifo_clk_o,
    output wire [5:0] init_latency_o,
    output wire quad_mode_o,
    output wire [35:0] user_data_o,
    output wire user_valid_o,
    input wire user_ready_i
);
    reg [31:0] ctrl_q;
    reg [31:0] wlo_q;
    reg [31:0] whi_q;
    reg [7:0] wbe_q;
    reg [31:0] addr_q;
    reg [31:0] last_addr_q;
    reg [31:0] part_q;
    reg [3:0] part_be_q;
    reg part_v_q;
    reg [31:0] skipped_q;
    reg [71:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    reg half_q;
    reg [35:0] ob_d0_q;
    reg [35:0] ob_d1_q;
    reg [1:0] ob_n_q;
    reg lead_q;
    reg [31:0] ctrl_d;
    reg [31:0] wlo_d;
    reg [31:0] whi_d;
    reg [7:0] wbe_d;
    reg [31:0] addr_d;
    reg [31:0] last_addr_d;
    reg [31:0] skipped_d;
    reg lead_d;
    reg [35:0] ob_d0_d;
    reg [35:0] ob_d1_d;
    reg [1:0] ob_n_d;
    reg [AW-1:0] wp_d;
    reg [AW-1:0] rp_d;
    reg [AW:0] cnt_d;
    reg half_d;
    localparam [AW:0] DEPTH_W = DEPTH;
    wire acc = psel_i && penable_i;
    wire wr = acc && pwrite_i;
    wire full = (cnt_q == DEPTH_W);
    wire empty = (cnt_q == {(AW+1){1'b0}});
    wire quad = ctrl_q[`PFP_CTRL_QUAD];
    wire push_w = wr && (paddr_i == `PFP_ADDR_RDAT);
    wire flush = wr && (paddr_i == `PFP_ADDR_LAST);
    reg push;
    reg [71:0] push_ent;
    reg [31:0] nxt_part;
    reg [3:0] nxt_part_be;
    reg nxt_part_v;
    wire ob_in_rdy = (ob_n_q != 2'd2);
    wire pop = !empty && ob_in_rdy;
    wire [71:0] head = mem[rp_q];
    // every entry leaves as two words, low half first
    wire last_half = half_q;
    wire ob_out = (ob_n_q != 2'd0) && user_ready_i;

    function [71:0] ent;
        input [31:0] lo;
        input [3:0] lo_be;
        input [31:0] hi;
        input [3:0] hi_be;
        begin
            ent = {hi_be, lo_be, hi, lo};
        end
    endfunction

    // wrap-around pointer step
    function [AW-1:0] bump;
        input [AW-1:0] ptr;
        begin
            bump = ptr + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    // half of a stored entry, its enables beside the word
    function [35:0] half_word;
        input [71:0] e;
        input hi;
        begin
            if (hi) begin
                half_word = {e[71:68], e[63:32]};
            end else begin
                half_word = {e[67:64], e[31:0]};
            end
        end
    endfunction

    // pcie-side burst path: 64-bit writes pass, 32-bit ones pack
    always @* begin
        push = 1'b0;
        push_ent = {72{1'b0}};
        nxt_part = part_q;
        nxt_part_be = part_be_q;
        nxt_part_v = part_v_q;
        if (push_w && ctrl_q[`PFP_CTRL_W64] && !full) begin
            push = 1'b1;
            push_ent = ent(wlo_q, wbe_q[3:0], whi_q, wbe_q[7:4]);
        end else if (push_w && !full) begin
            if (part_v_q) begin
                push = 1'b1;
                push_ent = ent(part_q, part_be_q, wlo_q, wbe_q[3:0]);
                nxt_part_v = 1'b0;
            end else if (lead_q) begin
                push = 1'b1;
                push_ent = ent(32'h0000_0000, `PFP_BE_NONE, wlo_q, wbe_q[3:0]);
            end else begin
                nxt_part = wlo_q;
                nxt_part_be = wbe_q[3:0];
                nxt_part_v = 1'b1;
            end
        end else if (flush && part_v_q && !full) begin
            push = 1'b1;
            push_ent = ent(part_q, part_be_q, 32'h0000_0000, `PFP_BE_NONE);
            nxt_part_v = 1'b0;
        end
    end

    // register file next values
    always @* begin
        ctrl_d = ctrl_q;
        wlo_d = wlo_q;
        whi_d = whi_q;
        wbe_d = wbe_q;
        addr_d = addr_q;
        last_addr_d = last_addr_q;
        skipped_d = skipped_q;
        lead_d = lead_q;
        if (wr) begin
            case (paddr_i)
                `PFP_ADDR_CTRL: ctrl_d = pwdata_i;
                `PFP_ADDR_WLO: wlo_d = pwdata_i;
                `PFP_ADDR_WHI: whi_d = pwdata_i;
                `PFP_ADDR_WBE: wbe_d = pwdata_i[7:0];
                `PFP_ADDR_ADDR: begin
                    addr_d = pwdata_i;
                    last_addr_d = addr_q;
                    lead_d = pwdata_i[`PFP_ADDR_LEAD];
                    // upper bytes already known are not resent
                    if (ctrl_q[`PFP_CTRL_ACMP] &&
                        ((pwdata_i & `PFP_ADDR_MSB) == (addr_q & `PFP_ADDR_MSB))) begin
                        skipped_d = skipped_q + 32'h0000_0001;
                    end
                end
                default: ;
            endcase
        end
        // odd leading word went out beside its dummy
        if (push && lead_q && !part_v_q && !ctrl_q[`PFP_CTRL_W64]) begin
            lead_d = 1'b0;
        end
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= `PFP_CTRL_RST;
            wlo_q <= 32'h0000_0000;
            whi_q <= 32'h0000_0000;
            wbe_q <= 8'h00;
            addr_q <= 32'h0000_0000;
            last_addr_q <= 32'h0000_0000;
            skipped_q <= 32'h0000_0000;
            lead_q <= 1'b0;
            part_q <= 32'h0000_0000;
            part_be_q <= `PFP_BE_NONE;
            part_v_q <= 1'b0;
        end else begin
            part_q <= nxt_part;
            part_be_q <= nxt_part_be;
            part_v_q <= nxt_part_v;
            ctrl_q <= ctrl_d;
            wlo_q <= wlo_d;
            whi_q <= whi_d;
            wbe_q <= wbe_d;
            addr_q <= addr_d;
            last_addr_q <= last_addr_d;
            skipped_q <= skipped_d;
            lead_q <= lead_d;
        end
    end

    // entry store
    always @(posedge mclk_i) begin
        if (push) begin
            mem[wp_q] <= push_ent;
        end
    end

    // store pointers: an entry retires after its high half
    always @* begin
        wp_d = wp_q;
        rp_d = rp_q;
        half_d = half_q;
        cnt_d = cnt_q;
        if (push) begin
            wp_d = bump(wp_q);
            cnt_d = cnt_d + {{AW{1'b0}}, 1'b1};
        end
        if (pop) begin
            half_d = ~half_q;
            if (last_half) begin
                rp_d = bump(rp_q);
                cnt_d = cnt_d - {{AW{1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            half_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            half_q <= half_d;
        end
    end

    // two-entry output buffer, 32-bit words plus active-low enables
    wire [35:0] pop_word = half_word(head, half_q);
    always @* begin
        ob_d0_d = ob_d0_q;
        ob_d1_d = ob_d1_q;
        ob_n_d = ob_n_q;
        case ({pop, ob_out})
            2'b10: begin
                if (ob_n_q == 2'd0) begin
                    ob_d0_d = pop_word;
                end else begin
                    ob_d1_d = pop_word;
                end
                ob_n_d = ob_n_q + 2'd1;
            end
            2'b01: begin
                ob_d0_d = ob_d1_q;
                ob_n_d = ob_n_q - 2'd1;
            end
            2'b11: begin
                if (ob_n_q == 2'd1) begin
                    ob_d0_d = pop_word;
                end else begin
                    ob_d0_d = ob_d1_q;
                    ob_d1_d = pop_word;
                end
            end
            default: begin
                ob_n_d = ob_n_q;
            end
        endcase
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ob_d0_q <= {`PFP_BE_NONE, 32'h0000_0000};
            ob_d1_q <= {`PFP_BE_NONE, 32'h0000_0000};
            ob_n_q <= 2'd0;
        end else begin
            ob_d0_q <= ob_d0_d;
            ob_d1_q <= ob_d1_d;
            ob_n_q <= ob_n_d;
        end
    end

    assign user_data_o = ob_d0_q;
    assign user_valid_o = (ob_n_q != 2'd0);
    assign quad_mode_o = quad;
    assign master_fifo_clk_o = ctrl_q[`PFP_CTRL_MCLK] ? array_clock_two_i
                                                       : array_clock_one_i;
    assign target_fifo_clk_o = ctrl_q[`PFP_CTRL_TCLK] ? array_clock_two_i
                                                       : array_clock_one_i;
    assign init_latency_o = ctrl_q[`PFP_CTRL_XLAT] ? `PFP_LAT_EXTENDED
                                                    : `PFP_LAT_NORMAL;

    // apb answers in the access cycle; writes to a full store are refused
    assign pready_o = 1'b1;
    reg bad;
    always @* begin
        bad = 1'b1;
        case (paddr_i)
            `PFP_ADDR_CTRL, `PFP_ADDR_STAT, `PFP_ADDR_WLO, `PFP_ADDR_WHI,
            `PFP_ADDR_WBE, `PFP_ADDR_ADDR: bad = 1'b0;
            `PFP_ADDR_RDAT, `PFP_ADDR_LAST: bad = pwrite_i && full;
            default: bad = 1'b1;
        endcase
    end
    assign pslverr_o = acc && bad;

    always @* begin
        case (paddr_i)
            `PFP_ADDR_CTRL: prdata_o = ctrl_q;
            `PFP_ADDR_STAT: prdata_o = {skipped_q[15:0], 5'd0, ob_n_q, part_v_q,
                                        half_q, full, empty, cnt_q};
            `PFP_ADDR_WLO: prdata_o = wlo_q;
            `PFP_ADDR_WHI: prdata_o = whi_q;
            `PFP_ADDR_WBE: prdata_o = {24'h000000, wbe_q};
            `PFP_ADDR_ADDR: prdata_o = last_addr_q;
            default: prdata_o = 32'h0000_0000;
        endcase
    end
endmodule // pfp_core
`default_nettype wire

/* pfp_core_chk.sv */
// assertion checker for the fifo packing core
`timescale 1ns/1ns
`default_nettype none
module pfp_core_chk (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic array_clock_one_i,
    input wire logic array_clock_two_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic master_fifo_clk_o,
    input wire logic target_fifo_clk_o,
    input wire logic [5:0] init_latency_o,
    input wire logic quad_mode_o,
    input wire logic [35:0] user_data_o,
    input wire logic user_valid_o,
    input wire logic user_ready_i
);
    logic [5:0] ctrl_q;
    wire acc = psel_i && penable_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // shadow of the control register
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= 6'h01;
        end else if (acc && pwrite_i && paddr_i == 12'h000) begin
            ctrl_q <= pwdata_i[5:0];
        end
    end
    chk_port_org: assert property (quad_mode_o == ctrl_q[0])
        else $error("port mode differs from control");
    chk_mclk_sel: assert property (master_fifo_clk_o ==
        (ctrl_q[1] ? array_clock_two_i : array_clock_one_i)) else $error("master clock pick");
    chk_tclk_sel: assert property (target_fifo_clk_o ==
        (ctrl_q[2] ? array_clock_two_i : array_clock_one_i)) else $error("target clock pick");
    chk_lat_sel: assert property (init_latency_o == (ctrl_q[4] ? 6'h20 : 6'h10))
        else $error("latency limit wrong");
    chk_word_hold: assert property (user_valid_o && !user_ready_i |=>
        user_valid_o && $stable(user_data_o)) else $error("stalled word changed");
    chk_reset_state: assert property ($fell(sys_rst_i) |-> !user_valid_o && quad_mode_o)
        else $error("reset state wrong");
    chk_unmapped_err: assert property (acc && paddr_i > 12'h01C |-> pslverr_o)
        else $error("unmapped access accepted");
    chk_zero_wait: assert property (acc |-> pready_o) else $error("access not ready");
    cover property (user_valid_o && !user_ready_i);
    cover property (acc && pslverr_o);
    cover property (ctrl_q[5] && user_valid_o && user_ready_i);
endmodule // pfp_core_chk
bind pfp_core pfp_core_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .array_clock_one_i(array_clock_one_i), .array_clock_two_i(array_clock_two_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .master_fifo_clk_o(master_fifo_clk_o), .target_fifo_clk_o(target_fifo_clk_o),
    .init_latency_o(init_latency_o), .quad_mode_o(quad_mode_o), .user_data_o(user_data_o),
    .user_valid_o(user_valid_o), .user_ready_i(user_ready_i));
`default_nettype wire

/* pfp_user_model.sv */
// user side consumer with random stalls
`timescale 1ns/1ns
`default_nettype none
module pfp_user_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input wire logic [35:0] data_i,
    input wire logic valid_i,
    output var logic ready_o
);
    integer seed = 32'h0BADCAFE;
    integer drops = 0;
    logic [31:0] got[$];
    initial ready_o = 1'b0;
    always @(posedge clk_i) begin
        if (valid_i && ready_o && !rst_i) begin
            if (data_i[35:32] === 4'hF) begin
                drops <= drops + 1;
            end else begin
                got.push_back(data_i[31:0]);
            end
        end
        ready_o <= !rst_i && !hold_i && ($random(seed) % 4 != 0);
    end
endmodule // pfp_user_model
`default_nettype wire

/* pfp_core_tb_top.sv */
// testbench for the fifo packing core
`timescale 1ns/1ns
`default_nettype none
`include "pfp_map.vh"
module pfp_core_tb_top;
    logic clk = 0, rst = 1, c1 = 0, c2 = 0, psel = 0, pen = 0, pwr = 0, hold = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, prd, prd_s;
    logic [35:0] ud;
    logic [63:0] v;
    logic rdy, pready, perr, err_s, uv, mf, tf, qm;
    logic [5:0] lat;
    logic [31:0] exp_q[$];
    integer error_cnt = 0, num_checks = 0, seed = 32'h3550557D, i, m, n, d0, s0;
    always #25 clk = ~clk;
    always #20 c1 = ~c1;
    always #30 c2 = ~c2;
    pfp_core #(.DEPTH(16), .AW(4)) dut (.mclk_i(clk), .sys_rst_i(rst),
        .array_clock_one_i(c1), .array_clock_two_i(c2), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready),
        .pslverr_o(perr), .master_fifo_clk_o(mf), .target_fifo_clk_o(tf),
        .init_latency_o(lat), .quad_mode_o(qm), .user_data_o(ud), .user_valid_o(uv),
        .user_ready_i(rdy));
    pfp_user_model um (.clk_i(clk), .rst_i(rst), .hold_i(hold), .data_i(ud),
        .valid_i(uv), .ready_o(rdy));
    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        prd_s = prd;
        err_s = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic cmp_out();
        for (i = 0; i < 600 && um.got.size() < exp_q.size(); i++) @(posedge clk);
        for (i = 0; i < 50 && uv !== 1'b0; i++) @(posedge clk);
        check("word count", um.got.size(), exp_q.size());
        foreach (exp_q[k]) check("user word", um.got[k], exp_q[k]);
        um.got.delete();
        exp_q.delete();
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `PFP_ADDR_CTRL, 32'h0);
        check("ctrl reset", prd_s, `PFP_CTRL_RST);
        for (m = 0; m < 32; m++) begin
            apb(1'b1, `PFP_ADDR_CTRL, m);
            @(negedge clk);
            #1;
            check("master clk", mf, m[1] ? c2 : c1);
            check("target clk", tf, m[2] ? c2 : c1);
            check("quad", qm, m[0]);
            check("latency", lat, m[4] ? `PFP_LAT_EXTENDED : `PFP_LAT_NORMAL);
        end
        apb(1'b1, `PFP_ADDR_WBE, 32'h0);
        apb(1'b1, `PFP_ADDR_ADDR, 32'h1000);
        for (m = 0; m < 2; m++) begin
            apb(1'b1, `PFP_ADDR_CTRL, 32'h21 - m);
            repeat (6) begin
                v = {$random(seed), $random(seed)};
                apb(1'b1, `PFP_ADDR_WLO, v[31:0]);
                apb(1'b1, `PFP_ADDR_WHI, v[63:32]);
                apb(1'b1, `PFP_ADDR_RDAT, 32'h0);
                exp_q.push_back(v[31:0]);
                exp_q.push_back(v[63:32]);
            end
            cmp_out();
        end
        apb(1'b1, `PFP_ADDR_CTRL, `PFP_CTRL_RST);
        for (m = 0; m < 3; m++) begin
            d0 = um.drops;
            apb(1'b1, `PFP_ADDR_ADDR, m == 2 ? 32'h1004 : 32'h1000);
            for (n = 0; n < (m == 0 ? 4 : 3); n++) begin
                v[31:0] = $random(seed);
                apb(1'b1, `PFP_ADDR_WLO, v[31:0]);
                apb(1'b1, `PFP_ADDR_RDAT, 32'h0);
                exp_q.push_back(v[31:0]);
            end
            apb(1'b1, `PFP_ADDR_LAST, 32'h0);
            cmp_out();
            check("dummy count", um.drops - d0, m != 0);
        end
        apb(1'b1, `PFP_ADDR_CTRL, 32'h21);
        hold <= 1'b1;
        err_s = 1'b0;
        for (n = 0; n < 40 && err_s !== 1'b1; n++) begin
            v = {$random(seed), $random(seed)};
            apb(1'b1, `PFP_ADDR_WLO, v[31:0]);
            apb(1'b1, `PFP_ADDR_WHI, v[63:32]);
            apb(1'b1, `PFP_ADDR_RDAT, 32'h0);
            if (err_s !== 1'b1) exp_q.push_back(v[31:0]);
            if (err_s !== 1'b1) exp_q.push_back(v[63:32]);
        end
        check("store refused", err_s, 1'b1);
        check("store depth", n > 16, 1'b1);
        hold <= 1'b0;
        cmp_out();
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped err", err_s, 1'b1);
        check("unmapped data", prd_s, 32'h0);
        apb(1'b1, `PFP_ADDR_CTRL, 32'h09);
        apb(1'b0, `PFP_ADDR_STAT, 32'h0);
        s0 = prd_s[31:16];
        apb(1'b1, `PFP_ADDR_ADDR, 32'h1000);
        apb(1'b1, `PFP_ADDR_ADDR, 32'h1008);
        apb(1'b1, `PFP_ADDR_CTRL, 32'h01);
        apb(1'b1, `PFP_ADDR_ADDR, 32'h1010);
        apb(1'b0, `PFP_ADDR_STAT, 32'h0);
        check("skip count", prd_s[31:16], s0 + 2);
        end_of_test();
    end
endmodule // pfp_core_tb_top
`default_nettype wire
